/* lfa_pkg.sv */
`default_nettype none
package lfa_pkg;
   // command nibbles
   localparam logic [3:0] CMD_AUTH = 4'h1;
   localparam logic [3:0] CMD_ENH = 4'h3;
   localparam logic [3:0] CMD_KEY1 = 4'h7;
   localparam logic [3:0] CMD_KEY2 = 4'h8;
   localparam logic [3:0] CMD_REP = 4'hE;
   // check nibble per command, entry n at bits [4n+3:4n]
   localparam logic [63:0] CHK_TABLE_DEF = 64'h0100_0D0B_9AFC_5630;
   localparam logic [7:0] CRC8_POLY_DEF = 8'h07;
   localparam logic [7:0] CRC8_INIT_DEF = 8'h00;
   localparam logic [7:0] SYNC_HDR = 8'hFE;
   // status codes, low nibble
   localparam logic [3:0] STS_OK = 4'h0;
   localparam logic [3:0] STS_CHK = 4'h1;
   localparam logic [3:0] STS_LEN = 4'h2;
   localparam logic [3:0] STS_CRC = 4'h3;
   localparam logic [3:0] STS_CMD = 4'h4;
   localparam logic [3:0] STS_CFG = 4'h5;
   // nonvolatile key areas and enhanced flag address
   localparam logic [11:0] KEY1_ADDR = 12'h7C0;
   localparam logic [11:0] KEY2_ADDR = 12'h780;
   localparam logic [11:0] KEY_STRIDE = 12'h010;
   localparam logic [1:0] KEY_LAST_COPY = 2'h2;
   localparam logic [11:0] ENH_FLAG_ADDR_DEF = 12'h7F0;
   // frame sizes in bytes, response memory address width
   localparam int unsigned CMD_BYTES = 1;
   localparam int unsigned CRC_BYTES = 1;
   localparam int unsigned KEY_BYTES = 16;
   localparam int unsigned MAX_PAY = 16;
   localparam int unsigned MEM_AW = 5;
   // configuration bits and reset values
   localparam int unsigned CM_BIT = 2;
   localparam int unsigned SKT_BIT = 6;
   localparam logic [7:0] CRYPTO_RST = 8'h00;
   localparam logic [7:0] CHAL_RST = 8'h0D;
   localparam logic [7:0] RESP_RST = 8'h07;
   // register indices, byte address is four times the index
   localparam int unsigned AXI_ADDR_W = 14;
   localparam logic [11:0] IDX_CRYPTO = 12'h811;
   localparam logic [11:0] IDX_CHAL = 12'h815;
   localparam logic [11:0] IDX_RESP = 12'h816;
   localparam logic [11:0] IDX_STATUS = 12'h820;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned PAUSE_US = 2000;
   localparam int unsigned PAUSE_CYC_DEF = PAUSE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ERR_FREQ_HZ = 1000;
   localparam int unsigned ERR_HALF_CYC_DEF = CLK_HZ / (2 * ERR_FREQ_HZ);
   localparam int unsigned ERR_PERIODS = 8;
   // link signal positions in the synchroniser
   localparam int unsigned LK_CLK = 0;
   localparam int unsigned LK_DAT = 1;
   localparam int unsigned LK_FRM = 2;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_RECV = 9'h002,
      ST_EXEC = 9'h004,
      ST_AESW = 9'h008,
      ST_NVMW = 9'h010,
      ST_BUILD = 9'h020,
      ST_PAUSE = 9'h040,
      ST_SEND = 9'h080,
      ST_ERRW = 9'h100
   } lfa_state_e;
endpackage
`default_nettype wire

/* lfa_resp_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module lfa_resp_mem #(
   parameter int unsigned DW = 8,
   parameter int unsigned AW = 5
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem_q [2**AW];

   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem_q[raddr];
   end
endmodule // lfa_resp_mem
`default_nettype wire

/* lfa_cmd_handler.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - command 0001b with check 0011 starts authentication with challenge and CRC
// - expected challenge length comes from challenge length configuration
// - response payload length comes from response length configuration
// - crypto config bit 2 picks one-way (0) or two-way (1) authentication
// - all authentication results come from the AES-128 engine
// - response payload 56 or 80 bits, after header, before CRC; the code takes any response length configuration of 1 to 16 bytes
// - command 0111b with check 1001 learns first key, 128 bits plus CRC
// - crypto config bit 6: plain key (0) or encrypted key (1)
// - first key stored at 0x7C0 with two redundant copies
// - command 1000b with check 1011 learns second key, same transfer bit
// - second key stored at 0x780 with two redundant copies
// - status byte lives in volatile storage, rewritten every session
// - status high nibble echoes command, low nibble encodes result
// - key learning answers with the status byte between header and CRC
// - command 0011b with check 0101 sets enhanced flag, answers status
// - enhanced flag checked at power-on to switch field supply off
// - battery session happens once per enhanced mode request
// - command 1110b with check 0001 resends the previous response frame
// - every response frame starts with header byte 0xFE
// - payload CRC byte only present when the frame carries payload
// - session is request, 2 ms pause, then response
// - any error answers with a fixed 1 kHz waveform instead
module lfa_cmd_handler #(
   parameter int unsigned PAUSE_CYC = lfa_pkg::PAUSE_CYC_DEF,
   parameter int unsigned ERR_HALF_CYC = lfa_pkg::ERR_HALF_CYC_DEF,
   parameter logic [11:0] ENH_FLAG_ADDR = lfa_pkg::ENH_FLAG_ADDR_DEF,
   parameter logic [63:0] CHK_TABLE = lfa_pkg::CHK_TABLE_DEF,
   parameter logic [7:0] CRC8_POLY = lfa_pkg::CRC8_POLY_DEF,
   parameter logic [7:0] CRC8_INIT = lfa_pkg::CRC8_INIT_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [lfa_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [lfa_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic lf_clk,
   input wire logic lf_rx_data,
   input wire logic lf_rx_frame,
   output logic lf_tx_data,
   output logic lf_tx_en,
   output logic aes_start,
   output logic aes_decrypt,
   output logic aes_two_way,
   output logic [127:0] aes_block,
   input wire logic aes_done,
   input wire logic [127:0] aes_result,
   output logic nvm_wr_valid,
   input wire logic nvm_wr_ready,
   output logic [11:0] nvm_wr_addr,
   output logic [127:0] nvm_wr_data,
   input wire logic enh_flag_nvm,
   output logic field_supply_state,
   output logic [7:0] status_byte
);
   import lfa_pkg::*;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ CRC8_POLY) : (r << 1);
      end
      return r;
   endfunction

   lfa_state_e st_q;
   logic [2:0] lk_ff1_q, lk_ff2_q, lk_ff3_q, lk_st_q;
   logic lk_clk_prev_q, lk_rise;
   logic [7:0] rx_bits_q, rx_sh_q, cmd_q, crc_run_q, crc_prev_q, rx_byte;
   logic [135:0] rx_data_q;
   logic [7:0] status_q, crypto_q, chal_q, resp_q;
   logic err_q, por_done_q, field_off_q;
   logic aes_start_q, aes_decrypt_q;
   logic [127:0] aes_block_q;
   logic nvm_valid_q, nvm_build_q;
   logic [11:0] nvm_addr_q;
   logic [127:0] nvm_data_q;
   logic [1:0] nvm_cnt_q, nvm_last_q;
   logic [127:0] resp_buf_q;
   logic [4:0] pay_len_q, bld_idx_q, tx_len_q, tx_idx_q;
   logic [7:0] bld_crc_q, bld_byte;
   logic [2:0] tx_bit_q;
   logic tx_data_q, tx_en_q;
   logic [31:0] pause_cnt_q, err_cnt_q;
   logic [4:0] err_half_q;
   logic [7:0] mem_rdata;
   logic [7:0] exp_d;
   logic [3:0] code_d;
   logic pay_d, known_d, cfg_bad;
   logic [127:0] blk_d;
   logic aw_got_q, w_got_q, w_en_q, bvalid_q, rvalid_q;
   logic [11:0] aw_idx_q;
   logic [7:0] w_data_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // link inputs: three stages, a change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lk_ff1_q <= 3'h0;
         lk_ff2_q <= 3'h0;
         lk_ff3_q <= 3'h0;
         lk_st_q <= 3'h0;
         lk_clk_prev_q <= 1'b0;
      end else begin
         lk_ff1_q <= {lf_rx_frame, lf_rx_data, lf_clk};
         lk_ff2_q <= lk_ff1_q;
         lk_ff3_q <= lk_ff2_q;
         for (int i = 0; i < 3; i++) begin
            if (lk_ff2_q[i] == lk_ff3_q[i]) begin
               lk_st_q[i] <= lk_ff3_q[i];
            end
         end
         lk_clk_prev_q <= lk_st_q[LK_CLK];
      end
   end
   assign lk_rise = lk_st_q[LK_CLK] & ~lk_clk_prev_q;
   assign rx_byte = {rx_sh_q[6:0], lk_st_q[LK_DAT]};

   // request receiver, msb first; payload crc runs over the data bytes
   always_ff @(posedge aclk) begin
      if (!aresetn || st_q == ST_IDLE) begin
         rx_bits_q <= 8'h00;
         rx_sh_q <= 8'h00;
         cmd_q <= 8'h00;
         rx_data_q <= '0;
         crc_run_q <= CRC8_INIT;
         crc_prev_q <= CRC8_INIT;
      end else if (st_q == ST_RECV && lk_rise && lk_st_q[LK_FRM]) begin
         rx_sh_q <= rx_byte;
         if (rx_bits_q != 8'hFF) begin
            rx_bits_q <= rx_bits_q + 8'h01;
         end
         if (rx_bits_q[2:0] == 3'h7) begin
            if (rx_bits_q[7:3] == 5'h00) begin
               cmd_q <= rx_byte;
            end else begin
               rx_data_q <= {rx_data_q[127:0], rx_byte};
               crc_prev_q <= crc_run_q;
               crc_run_q <= crc8(crc_run_q, rx_byte);
            end
         end
      end
   end

   // request decode
   always_comb begin
      exp_d = 8'(CMD_BYTES);
      pay_d = 1'b0;
      known_d = 1'b1;
      case (cmd_q[7:4])
         CMD_AUTH: begin
            exp_d = 8'(CMD_BYTES + CRC_BYTES) + chal_q;
            pay_d = 1'b1;
         end
         CMD_KEY1, CMD_KEY2: begin
            exp_d = 8'(CMD_BYTES + KEY_BYTES + CRC_BYTES);
            pay_d = 1'b1;
         end
         CMD_ENH, CMD_REP: exp_d = 8'(CMD_BYTES);
         default: known_d = 1'b0;
      endcase
      cfg_bad = (cmd_q[7:4] == CMD_AUTH) && (chal_q == 8'h00 || chal_q > 8'(MAX_PAY)
         || resp_q == 8'h00 || resp_q > 8'(MAX_PAY));
      if (!known_d) begin
         code_d = STS_CMD;
      end else if (CHK_TABLE[{cmd_q[7:4], 2'b00} +: 4] != cmd_q[3:0]) begin
         code_d = STS_CHK;
      end else if (cfg_bad) begin
         code_d = STS_CFG;
      end else if ({3'h0, rx_bits_q[7:3]} != exp_d || rx_bits_q[2:0] != 3'h0) begin
         code_d = STS_LEN;
      end else if (pay_d && crc_prev_q != rx_data_q[7:0]) begin
         code_d = STS_CRC;
      end else begin
         code_d = STS_OK;
      end
      // challenge left aligned in the cipher block
      blk_d = rx_data_q[135:8] << {5'(MAX_PAY) - chal_q[4:0], 3'b000};
   end

   // pause counted from the end of the request
   always_ff @(posedge aclk) begin
      if (!aresetn || (st_q == ST_RECV && !lk_st_q[LK_FRM])) begin
         pause_cnt_q <= 32'h0;
      end else if (pause_cnt_q != 32'(PAUSE_CYC)) begin
         pause_cnt_q <= pause_cnt_q + 32'h1;
      end
   end

   // header first, then payload, crc last
   always_comb begin
      if (bld_idx_q == 5'h00) begin
         bld_byte = SYNC_HDR;
      end else if (bld_idx_q <= pay_len_q) begin
         bld_byte = resp_buf_q[127:120];
      end else begin
         bld_byte = bld_crc_q;
      end
   end

   lfa_resp_mem #(
      .DW(8),
      .AW(MEM_AW)
   ) u_resp_mem (
      .clk(aclk),
      .we(st_q == ST_BUILD),
      .waddr(bld_idx_q),
      .wdata(bld_byte),
      .raddr(tx_idx_q),
      .rdata(mem_rdata)
   );

   task automatic nvm_go(input logic [11:0] a, input logic [127:0] d,
                         input logic [1:0] last, input logic build);
      nvm_valid_q <= 1'b1;
      nvm_addr_q <= a;
      nvm_data_q <= d;
      nvm_cnt_q <= 2'h0;
      nvm_last_q <= last;
      nvm_build_q <= build;
      st_q <= ST_NVMW;
   endtask

   // session sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_IDLE;
         status_q <= 8'h00;
         err_q <= 1'b0;
         por_done_q <= 1'b0;
         field_off_q <= 1'b0;
         aes_start_q <= 1'b0;
         aes_decrypt_q <= 1'b0;
         aes_block_q <= '0;
         nvm_valid_q <= 1'b0;
         nvm_build_q <= 1'b0;
         nvm_addr_q <= 12'h000;
         nvm_data_q <= '0;
         nvm_cnt_q <= 2'h0;
         nvm_last_q <= 2'h0;
         resp_buf_q <= '0;
         pay_len_q <= 5'h00;
         bld_idx_q <= 5'h00;
         bld_crc_q <= CRC8_INIT;
         tx_len_q <= 5'h00;
         tx_idx_q <= 5'h00;
         tx_bit_q <= 3'h0;
         tx_data_q <= 1'b0;
         tx_en_q <= 1'b0;
         err_cnt_q <= 32'h0;
         err_half_q <= 5'h00;
      end else if (!por_done_q) begin
         por_done_q <= 1'b1;
         field_off_q <= enh_flag_nvm;
         if (enh_flag_nvm) begin
            nvm_go(ENH_FLAG_ADDR, '0, 2'h0, 1'b0);
         end
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (lk_st_q[LK_FRM]) begin
                  st_q <= ST_RECV;
               end
            end
            ST_RECV: begin
               if (!lk_st_q[LK_FRM]) begin
                  st_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               status_q <= {cmd_q[7:4], code_d};
               if (code_d != STS_OK) begin
                  err_q <= 1'b1;
                  st_q <= ST_PAUSE;
               end else begin
                  case (cmd_q[7:4])
                     CMD_AUTH: begin
                        aes_block_q <= blk_d;
                        aes_decrypt_q <= 1'b0;
                        aes_start_q <= 1'b1;
                        st_q <= ST_AESW;
                     end
                     CMD_KEY1, CMD_KEY2: begin
                        if (crypto_q[SKT_BIT]) begin
                           aes_block_q <= rx_data_q[135:8];
                           aes_decrypt_q <= 1'b1;
                           aes_start_q <= 1'b1;
                           st_q <= ST_AESW;
                        end else begin
                           nvm_go(cmd_q[7:4] == CMD_KEY1 ? KEY1_ADDR : KEY2_ADDR,
                                  rx_data_q[135:8], KEY_LAST_COPY, 1'b1);
                        end
                     end
                     CMD_ENH: nvm_go(ENH_FLAG_ADDR, 128'h1, 2'h0, 1'b1);
                     default: st_q <= ST_PAUSE;
                  endcase
               end
            end
            ST_AESW: begin
               aes_start_q <= 1'b0;
               if (aes_done) begin
                  if (cmd_q[7:4] == CMD_AUTH) begin
                     resp_buf_q <= aes_result;
                     pay_len_q <= resp_q[4:0];
                     bld_idx_q <= 5'h00;
                     st_q <= ST_BUILD;
                  end else begin
                     nvm_go(cmd_q[7:4] == CMD_KEY1 ? KEY1_ADDR : KEY2_ADDR,
                            aes_result, KEY_LAST_COPY, 1'b1);
                  end
               end
            end
            ST_NVMW: begin
               if (nvm_wr_ready) begin
                  if (nvm_cnt_q == nvm_last_q) begin
                     nvm_valid_q <= 1'b0;
                     resp_buf_q <= {status_q, 120'h0};
                     pay_len_q <= 5'h01;
                     bld_idx_q <= 5'h00;
                     st_q <= nvm_build_q ? ST_BUILD : ST_IDLE;
                  end else begin
                     nvm_cnt_q <= nvm_cnt_q + 2'h1;
                     nvm_addr_q <= nvm_addr_q + KEY_STRIDE;
                  end
               end
            end
            ST_BUILD: begin
               if (bld_idx_q == 5'h00) begin
                  bld_crc_q <= CRC8_INIT;
               end else if (bld_idx_q <= pay_len_q) begin
                  bld_crc_q <= crc8(bld_crc_q, bld_byte);
                  resp_buf_q <= resp_buf_q << 8;
               end
               if (bld_idx_q == pay_len_q + 5'h01) begin
                  tx_len_q <= pay_len_q + 5'h02;
                  st_q <= ST_PAUSE;
               end else begin
                  bld_idx_q <= bld_idx_q + 5'h01;
               end
            end
            ST_PAUSE: begin
               // answer only after the pause
               // address held at zero so the first byte is read before the first link edge
               tx_idx_q <= 5'h00;
               if (pause_cnt_q == 32'(PAUSE_CYC)) begin
                  tx_bit_q <= 3'h0;
                  err_cnt_q <= 32'h0;
                  err_half_q <= 5'h00;
                  if (err_q) begin
                     tx_en_q <= 1'b1;
                     tx_data_q <= 1'b1;
                     st_q <= ST_ERRW;
                  end else begin
                     st_q <= ST_SEND;
                  end
               end
            end
            ST_SEND: begin
               // bits change on link rising edges; memory read settles between them
               if (lk_rise) begin
                  if (tx_idx_q == tx_len_q) begin
                     tx_en_q <= 1'b0;
                     tx_data_q <= 1'b0;
                     st_q <= ST_IDLE;
                  end else begin
                     tx_en_q <= 1'b1;
                     tx_data_q <= mem_rdata[~tx_bit_q];
                     tx_bit_q <= tx_bit_q + 3'h1;
                     if (tx_bit_q == 3'h7) begin
                        tx_idx_q <= tx_idx_q + 5'h01;
                     end
                  end
               end
            end
            ST_ERRW: begin
               if (err_cnt_q == 32'(ERR_HALF_CYC - 1)) begin
                  err_cnt_q <= 32'h0;
                  tx_data_q <= ~tx_data_q;
                  err_half_q <= err_half_q + 5'h01;
                  if (err_half_q == 5'(2 * ERR_PERIODS - 1)) begin
                     tx_en_q <= 1'b0;
                     tx_data_q <= 1'b0;
                     err_q <= 1'b0;
                     st_q <= ST_IDLE;
                  end
               end else begin
                  err_cnt_q <= err_cnt_q + 32'h1;
               end
            end
         endcase
      end
   end

   // register write path, address and data accepted in either order
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready = !w_got_q && !bvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         w_en_q <= 1'b0;
         aw_idx_q <= 12'h000;
         w_data_q <= 8'h00;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         crypto_q <= CRYPTO_RST;
         chal_q <= CHAL_RST;
         resp_q <= RESP_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[AXI_ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_en_q <= s_axi_wstrb[0];
         end
         if (aw_got_q && w_got_q) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= RESP_OKAY;
            case (aw_idx_q)
               IDX_CRYPTO: if (w_en_q) crypto_q <= w_data_q;
               IDX_CHAL: if (w_en_q) chal_q <= w_data_q;
               IDX_RESP: if (w_en_q) resp_q <= w_data_q;
               IDX_STATUS: ;
               default: bresp_q <= RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // register read path
   assign s_axi_arready = !rvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         case (s_axi_araddr[AXI_ADDR_W-1:2])
            IDX_CRYPTO: rdata_q <= {24'h0, crypto_q};
            IDX_CHAL: rdata_q <= {24'h0, chal_q};
            IDX_RESP: rdata_q <= {24'h0, resp_q};
            IDX_STATUS: rdata_q <= {24'h0, status_q};
            default: begin
               rdata_q <= 32'h0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign lf_tx_data = tx_data_q;
   assign lf_tx_en = tx_en_q;
   assign aes_start = aes_start_q;
   assign aes_decrypt = aes_decrypt_q;
   assign aes_two_way = crypto_q[CM_BIT];
   assign aes_block = aes_block_q;
   assign nvm_wr_valid = nvm_valid_q;
   assign nvm_wr_addr = nvm_addr_q;
   assign nvm_wr_data = nvm_data_q;
   assign field_supply_state = field_off_q;
   assign status_byte = status_q;
endmodule // lfa_cmd_handler
`default_nettype wire

/* lfa_cmd_handler_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lfa_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic lf_rx_frame,
   input wire logic lf_tx_data,
   input wire logic lf_tx_en,
   input wire logic aes_start,
   input wire logic nvm_wr_valid,
   input wire logic nvm_wr_ready,
   input wire logic [11:0] nvm_wr_addr,
   input wire logic enh_flag_nvm,
   input wire logic field_supply_state
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   aes_pulse_a: assert property (aes_start |=> !aes_start) else $error("aes pulse");
   nvm_hold_a: assert property (nvm_wr_valid && !nvm_wr_ready
      |=> nvm_wr_valid && $stable(nvm_wr_addr)) else $error("nvm write dropped");
   key_addr_a: assert property (nvm_wr_valid |-> nvm_wr_addr inside
      {12'h7C0, 12'h7D0, 12'h7E0, 12'h780, 12'h790, 12'h7A0, 12'h7F0}) else $error("nvm addr");
   hdr_first_a: assert property ($rose(lf_tx_en) |-> lf_tx_data) else $error("first bit");
   tx_quiet_a: assert property (!lf_tx_en |-> !lf_tx_data) else $error("idle data");
   pause_len_a: assert property ($rose(lf_tx_en) |-> !$past(lf_rx_frame, 150))
      else $error("pause too short");
   supply_set_a: assert property ($rose(field_supply_state) |-> $past(enh_flag_nvm))
      else $error("supply switch");
   supply_keep_a: assert property (!$fell(field_supply_state)) else $error("supply back");
endmodule // lfa_chk
bind lfa_cmd_handler lfa_chk u_chk (.*);
`default_nettype wire

/* lfa_base_stn.sv */
`timescale 1ns/1ps
`default_nettype none
module lfa_base_stn (
   output logic lf_clk,
   output logic lf_rx_data,
   output logic lf_rx_frame,
   input wire logic lf_tx_data,
   input wire logic lf_tx_en
);
   logic [31:0] rsp;
   int nrsp;
   initial {lf_clk, lf_rx_data, lf_rx_frame} = 3'h0;
   // msb first, clock runs only in sessions
   task automatic xfer(input logic [167:0] f, input int n);
      rsp = 0;
      nrsp = 0;
      lf_rx_frame = 1;
      for (int i = 0; i < n; i++) begin
         lf_rx_data = f[167-i];
         #80 lf_clk = 1;
         #80 lf_clk = 0;
      end
      #80 lf_rx_frame = 0;
      // released line, never a stale bit
      lf_rx_data = ~lf_rx_data;
      for (int i = 0; i < 600 && !(nrsp > 0 && !lf_tx_en); i++) begin
         #5 lf_clk = 1;
         #80 lf_clk = 0;
         #75 rsp = lf_tx_en ? {rsp[30:0], lf_tx_data} : rsp;
         nrsp += lf_tx_en;
      end
   endtask
endmodule // lfa_base_stn
`default_nettype wire

/* lf_auth_key_command_handler_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module lf_auth_key_command_handler_bench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, lf_clk;
   logic lf_rx_data, lf_rx_frame, lf_tx_data, lf_tx_en, aes_start, aes_decrypt, aes_two_way;
   logic aes_done, nvm_wr_valid, nvm_wr_ready, enh_flag_nvm, field_supply_state;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic [127:0] aes_block, aes_result, nvm_wr_data;
   logic [11:0] nvm_wr_addr;
   logic [7:0] status_byte;
   logic [3:0] s_axi_wstrb;
   int n_mismatch, cmp_count, nkey;
   lfa_cmd_handler #(.PAUSE_CYC(200), .ERR_HALF_CYC(20)) uut (.*);
   lfa_base_stn bs (.*);
   initial begin
      aclk = 0;
      forever #10 aclk = ~aclk;
   end
   // memory and cipher stubs, memory one cycle slow
   always @(posedge aclk) begin
      nvm_wr_ready <= nvm_wr_valid && !nvm_wr_ready;
      aes_done <= aes_start;
      if (nvm_wr_valid && nvm_wr_ready && nvm_wr_addr == 12'h7F0) enh_flag_nvm <= nvm_wr_data[0];
      else if (nvm_wr_valid && nvm_wr_ready) nkey <= nkey + 1;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] d);
      logic [7:0] c;
      c = d;
      for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      return c;
   endfunction
   // one bus cycle, write or read, held until answered
   task automatic axi(input logic w, input logic [13:0] a, input logic [31:0] d);
      logic dn = 0;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      for (int i = 0; i < 40 && !dn; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_arready) s_axi_arvalid <= 0;
         dn = w ? s_axi_bvalid : s_axi_rvalid;
         rd_d = s_axi_rdata;
         rd_r = w ? s_axi_bresp : s_axi_rresp;
         if (dn) {s_axi_bready, s_axi_rready} <= 2'h0;
      end
      if (!dn) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic ses(input logic [167:0] f, input int n, input logic [7:0] st, pl);
      bs.xfer(f, n);
      chk("status", 32'(status_byte), 32'(st));
      chk("frame", bs.rsp, {8'h0, 8'hFE, pl, crc8(pl)});
   endtask
   task automatic rst();
      aresetn <= 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      repeat (20) @(posedge aclk);
   endtask
   task automatic t_regs();
      axi(0, 14'h2054, 0);
      chk("chal len", rd_d, 32'h0D);
      axi(1, 14'h2058, 32'h1);
      axi(0, 14'h2058, 0);
      chk("resp len", rd_d, 32'h1);
      axi(1, 14'h2044, 32'h44);
      chk("two way", 32'(aes_two_way), 32'h1);
      axi(0, 14'h3000, 0);
      chk("unmapped", 32'(rd_r), 32'h2);
   endtask
   task automatic t_enh();
      ses({8'h35, 160'h0}, 8, 8'h30, 8'h30);
      chk("flag", 32'(enh_flag_nvm), 32'h1);
      ses({8'hE1, 160'h0}, 8, 8'hE0, 8'h30);
   endtask
   task automatic t_key();
      ses({8'h79, 160'h0}, 144, 8'h70, 8'h70);
      ses({8'h8B, 160'h0}, 144, 8'h80, 8'h80);
      chk("key writes", 32'(nkey), 32'h6);
      chk("decrypt", 32'(aes_decrypt), 32'h1);
   endtask
   task automatic t_auth();
      // 104 bit challenge, one byte answer
      ses({8'h13, 160'h0}, 120, 8'h10, 8'hC3);
   endtask
   task automatic t_err();
      bs.xfer({8'h10, 160'h0}, 8);
      chk("bad check", 32'(status_byte), 32'h11);
      chk("err wave", 32'(bs.nrsp > 30), 32'h1);
      bs.xfer({8'hB0, 160'h0}, 8);
      chk("bad cmd", 32'(status_byte), 32'hB4);
   endtask
   task automatic t_power();
      rst();
      chk("battery", 32'(field_supply_state), 32'h1);
      rst();
      chk("once", 32'(field_supply_state), 32'h0);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nvm_wr_ready, aes_done, enh_flag_nvm} = 0;
      {s_axi_wstrb, aes_result, n_mismatch, cmp_count, nkey} = {4'hF, {16{8'hC3}}, 96'h0};
      rst();
      t_regs();
      t_enh();
      t_key();
      t_auth();
      t_err();
      t_power();
      stop_test();
   end
endmodule // lf_auth_key_command_handler_bench
`default_nettype wire
